// ===== test/ccg_clock_ctrl_tb.sv
// Self-checking testbench of the clock divider and gating block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ccg_pkg::*;
   localparam int TIMEOUT_CYC = 60000;
   localparam int SETTLE_CYC = 200;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   ccg_axi_req_t axi_req = '0;
   ccg_axi_rsp_t axi_rsp;
   logic hclk_tick, pclk_tick, spi_clk_tick, timer_clk_tick, otp_clk_gate;
   logic quad_clk_gate, first_uart_clock_gate, second_uart_clock_gate, i2c_clk_gate;
   logic wakeup_capture_timer_clock_gate, general_timer_clock_gate;
   logic [2:0] xtal_coarse_trim;
   logic [7:0] xtal_fine_trim;
   logic [5:0] gates;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   int gate_bit [6] = '{15, 7, 6, 5, 4, 3};

   assign gates = {quad_clk_gate, first_uart_clock_gate, second_uart_clock_gate, i2c_clk_gate,
      wakeup_capture_timer_clock_gate, general_timer_clock_gate};

   ccg_clock_ctrl ccg_clock_ctrl_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .axi_req(axi_req),
      .axi_rsp(axi_rsp),
      .hclk_tick(hclk_tick),
      .pclk_tick(pclk_tick),
      .spi_clk_tick(spi_clk_tick),
      .timer_clk_tick(timer_clk_tick),
      .otp_clk_gate(otp_clk_gate),
      .quad_clk_gate(quad_clk_gate),
      .first_uart_clock_gate(first_uart_clock_gate),
      .second_uart_clock_gate(second_uart_clock_gate),
      .i2c_clk_gate(i2c_clk_gate),
      .wakeup_capture_timer_clock_gate(wakeup_capture_timer_clock_gate),
      .general_timer_clock_gate(general_timer_clock_gate),
      .xtal_coarse_trim(xtal_coarse_trim),
      .xtal_fine_trim(xtal_fine_trim)
   );

   // ****************************************
   // Clock, timeout
   // ****************************************
   always #5 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYC) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected timeout: expected done seen hang");
         end_of_test();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : cmp

   task automatic apply_reset;
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : apply_reset

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] exp_r);
      logic aw_done;
      logic w_done;
      logic tk_aw;
      logic tk_w;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge mclk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= s;
      axi_req.bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge mclk);
         tk_aw = axi_req.awvalid && (axi_rsp.awready === 1'b1);
         tk_w = axi_req.wvalid && (axi_rsp.wready === 1'b1);
         @(posedge mclk);
         if (tk_aw) begin
            axi_req.awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (tk_w) begin
            axi_req.wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      do @(negedge mclk); while (axi_rsp.bvalid !== 1'b1);
      cmp("bresp", {30'h0, exp_r}, {30'h0, axi_rsp.bresp});
      @(posedge mclk);
      axi_req.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
      @(posedge mclk);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do @(negedge mclk); while (axi_rsp.arready !== 1'b1);
      @(posedge mclk);
      axi_req.arvalid <= 1'b0;
      do @(negedge mclk); while (axi_rsp.rvalid !== 1'b1);
      cmp("rdata", exp_d, axi_rsp.rdata);
      cmp("rresp", {30'h0, exp_r}, {30'h0, axi_rsp.rresp});
      @(posedge mclk);
      axi_req.rready <= 1'b0;
   endtask : rd

   function automatic logic tick(input int sel);
      case (sel)
         0: return hclk_tick;
         1: return pclk_tick;
         2: return spi_clk_tick;
         default: return timer_clk_tick;
      endcase
   endfunction : tick

   // Period between the fourth and fifth pulse, after the setting has settled
   task automatic period(input int sel, input int exp_p);
      int n;
      int edges;
      int last;
      n = 0;
      edges = 0;
      last = 0;
      while (edges < 5) begin
         @(negedge mclk);
         n = n + 1;
         if (tick(sel) === 1'b1) begin
            edges = edges + 1;
            last = n;
            n = 0;
         end
      end
      cmp("tick period", exp_p, last);
   endtask : period

   task automatic quiet(input int sel);
      int seen;
      seen = 0;
      repeat (20) begin
         @(negedge mclk);
         if (tick(sel) !== 1'b0) seen = seen + 1;
      end
      cmp("gated tick count", 0, seen);
   endtask : quiet

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] v;
      logic [1:0] held;
      int flips;
      apply_reset();
      rd(CCG_ADDR_BUS, 32'h0000_0022, CCG_RESP_OKAY);
      rd(CCG_ADDR_TRIM, 32'h0000_0000, CCG_RESP_OKAY);
      rd(CCG_ADDR_PER, 32'h0000_0000, CCG_RESP_OKAY);
      period(0, 4);
      period(1, 16);
      quiet(2);
      quiet(3);
      cmp("gates", 6'h00, gates);
      cmp("otp gate", 1'b0, otp_clk_gate);
      wr(CCG_ADDR_BUS, 32'hFFFF_FFFF, 4'hF, CCG_RESP_OKAY);
      rd(CCG_ADDR_BUS, 32'h0000_00B3, CCG_RESP_OKAY);
      cmp("otp gate", 1'b1, otp_clk_gate);
      wr(CCG_ADDR_PER, 32'hFFFF_FFFF, 4'hF, CCG_RESP_OKAY);
      rd(CCG_ADDR_PER, 32'h0000_8BFB, CCG_RESP_OKAY);
      cmp("gates", 6'h3F, gates);
      wr(8'h04, 32'h0000_0000, 4'hF, CCG_RESP_SLVERR);
      rd(8'h0C, 32'h0000_0000, CCG_RESP_SLVERR);
      rd(CCG_ADDR_BUS, 32'h0000_00B3, CCG_RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         v = 32'h1 << gate_bit[i];
         wr(CCG_ADDR_PER, v, 4'h3, CCG_RESP_OKAY);
         cmp("gates", 6'h20 >> i, gates);
      end
      for (int k = 0; k < 4; k++) begin
         v = (k << 4) | k | ((k % 2) << 7);
         wr(CCG_ADDR_BUS, v, 4'h1, CCG_RESP_OKAY);
         cmp("otp gate", k % 2, otp_clk_gate);
         period(0, 1 << k);
         period(1, 1 << (2 * k));
         v = 32'h0808 | (k << 8) | k;
         wr(CCG_ADDR_PER, v, 4'h3, CCG_RESP_OKAY);
         period(2, 1 << k);
         period(3, 1 << k);
      end
      wr(CCG_ADDR_PER, 32'h0000_0000, 4'h3, CCG_RESP_OKAY);
      quiet(2);
      quiet(3);
      wr(CCG_ADDR_TRIM, 32'h0000_FFFF, 4'h1, CCG_RESP_OKAY);
      rd(CCG_ADDR_TRIM, 32'h0000_00FF, CCG_RESP_OKAY);
      cmp("fine trim", 8'hFF, xtal_fine_trim);
      // Coarse trim walked up one code at a time, settle wait shortened
      for (int c = 1; c < 8; c++) begin
         wr(CCG_ADDR_TRIM, (c << 8) | 32'hFF, 4'h3, CCG_RESP_OKAY);
         cmp("coarse trim", c, xtal_coarse_trim);
         repeat (SETTLE_CYC) @(posedge mclk);
      end
      wr(CCG_ADDR_TRIM, 32'hFFFF_FFFF, 4'hF, CCG_RESP_OKAY);
      rd(CCG_ADDR_TRIM, 32'h0000_07FF, CCG_RESP_OKAY);
      apply_reset();
      rd(CCG_ADDR_BUS, 32'h0000_0022, CCG_RESP_OKAY);
      cmp("trims", 11'h000, {xtal_coarse_trim, xtal_fine_trim});
      period(0, 4);
      // Clock enable low: bus ticks must hold still
      @(posedge mclk);
      ce <= 1'b0;
      @(negedge mclk);
      held = {hclk_tick, pclk_tick};
      flips = 0;
      repeat (20) begin
         @(negedge mclk);
         if ({hclk_tick, pclk_tick} !== held) flips = flips + 1;
      end
      cmp("frozen tick changes", 0, flips);
      @(posedge mclk);
      ce <= 1'b1;
      period(0, 4);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire

// ===== verilog/ccg_clock_ctrl.sv
// Clock divider and gating control with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module ccg_clock_ctrl #(
   parameter int DIV_SEL_W = 2,
   parameter int DIV_CNT_W = 3
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire ccg_pkg::ccg_axi_req_t axi_req,
   output var ccg_pkg::ccg_axi_rsp_t axi_rsp,
   output logic hclk_tick,
   output logic pclk_tick,
   output logic spi_clk_tick,
   output logic timer_clk_tick,
   output logic otp_clk_gate,
   output logic quad_clk_gate,
   output logic first_uart_clock_gate,
   output logic second_uart_clock_gate,
   output logic i2c_clk_gate,
   output logic wakeup_capture_timer_clock_gate,
   output logic general_timer_clock_gate,
   output logic [2:0] xtal_coarse_trim,
   output logic [7:0] xtal_fine_trim
);
   import ccg_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] bus_clock_divider_ctrl_reg;
   logic [15:0] crystal_trim_ctrl_reg;
   logic [15:0] peripheral_clock_ctrl_reg;

   logic awready_reg;
   logic wready_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [CCG_ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // ****************************************
   // Bus decode
   // ****************************************
   wire logic aw_take = axi_req.awvalid && awready_reg;
   wire logic w_take = axi_req.wvalid && wready_reg;
   wire logic do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   wire logic b_done = bvalid_reg && axi_req.bready;
   wire logic ar_take = axi_req.arvalid && arready_reg;
   wire logic r_done = rvalid_reg && axi_req.rready;

   wire logic wr_bus = do_write && (waddr_reg == CCG_ADDR_BUS);
   wire logic wr_trim = do_write && (waddr_reg == CCG_ADDR_TRIM);
   wire logic wr_per = do_write && (waddr_reg == CCG_ADDR_PER);
   wire logic wr_hit = wr_bus || wr_trim || wr_per;

   wire logic [15:0] strb_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire logic [15:0] bus_clock_divider_ctrl_next = (bus_clock_divider_ctrl_reg & ~strb_mask)
      | (wdata_reg[15:0] & strb_mask & CCG_BUS_MASK);
   wire logic [15:0] crystal_trim_ctrl_next = (crystal_trim_ctrl_reg & ~strb_mask)
      | (wdata_reg[15:0] & strb_mask & CCG_TRIM_MASK);
   wire logic [15:0] peripheral_clock_ctrl_next = (peripheral_clock_ctrl_reg & ~strb_mask)
      | (wdata_reg[15:0] & strb_mask & CCG_PER_MASK);

   wire logic rd_bus = axi_req.araddr == CCG_ADDR_BUS;
   wire logic rd_trim = axi_req.araddr == CCG_ADDR_TRIM;
   wire logic rd_per = axi_req.araddr == CCG_ADDR_PER;
   wire logic rd_hit = rd_bus || rd_trim || rd_per;
   wire logic [15:0] rd_value = rd_bus ? bus_clock_divider_ctrl_reg :
      rd_trim ? crystal_trim_ctrl_reg :
      rd_per ? peripheral_clock_ctrl_reg : 16'h0000;

   // ****************************************
   // Write channel
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= CCG_RESP_OKAY;
      end else if (ce) begin
         if (aw_take) begin
            awready_reg <= 1'b0;
            aw_have_reg <= 1'b1;
            waddr_reg <= axi_req.awaddr;
         end
         if (w_take) begin
            wready_reg <= 1'b0;
            w_have_reg <= 1'b1;
            wdata_reg <= axi_req.wdata;
            wstrb_reg <= axi_req.wstrb;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? CCG_RESP_OKAY : CCG_RESP_SLVERR;
         end
         if (b_done) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_clock_divider_ctrl_reg <= CCG_BUS_RST;
         crystal_trim_ctrl_reg <= CCG_TRIM_RST;
         peripheral_clock_ctrl_reg <= CCG_PER_RST;
      end else if (ce) begin
         if (wr_bus) begin
            bus_clock_divider_ctrl_reg <= bus_clock_divider_ctrl_next;
         end
         if (wr_trim) begin
            crystal_trim_ctrl_reg <= crystal_trim_ctrl_next;
         end
         if (wr_per) begin
            peripheral_clock_ctrl_reg <= peripheral_clock_ctrl_next;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= CCG_RESP_OKAY;
      end else if (ce) begin
         if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0000, rd_value};
            rresp_reg <= rd_hit ? CCG_RESP_OKAY : CCG_RESP_SLVERR;
         end else if (r_done) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   assign axi_rsp.awready = awready_reg;
   assign axi_rsp.wready = wready_reg;
   assign axi_rsp.bvalid = bvalid_reg;
   assign axi_rsp.bresp = bresp_reg;
   assign axi_rsp.arready = arready_reg;
   assign axi_rsp.rvalid = rvalid_reg;
   assign axi_rsp.rdata = rdata_reg;
   assign axi_rsp.rresp = rresp_reg;

   // ****************************************
   // Clock ticks
   // ****************************************
   logic [DIV_SEL_W-1:0] hclk_active;
   logic [DIV_SEL_W-1:0] pclk_active;

   ccg_div_tick #(.SEL_W(DIV_SEL_W), .CNT_W(DIV_CNT_W)) u_hclk_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .tick_in(1'b1),
      .gate(1'b1),
      .div_sel(bus_clock_divider_ctrl_reg[CCG_HDIV_LSB +: DIV_SEL_W]),
      .tick_out(hclk_tick),
      .active_sel(hclk_active)
   );

   ccg_div_tick #(.SEL_W(DIV_SEL_W), .CNT_W(DIV_CNT_W)) u_pclk_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .tick_in(hclk_tick),
      .gate(1'b1),
      .div_sel(bus_clock_divider_ctrl_reg[CCG_PDIV_LSB +: DIV_SEL_W]),
      .tick_out(pclk_tick),
      .active_sel(pclk_active)
   );

   ccg_div_tick #(.SEL_W(DIV_SEL_W), .CNT_W(DIV_CNT_W)) u_spi_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .tick_in(1'b1),
      .gate(peripheral_clock_ctrl_reg[CCG_SPI_BIT]),
      .div_sel(peripheral_clock_ctrl_reg[CCG_SDIV_LSB +: DIV_SEL_W]),
      .tick_out(spi_clk_tick),
      .active_sel()
   );

   ccg_div_tick #(.SEL_W(DIV_SEL_W), .CNT_W(DIV_CNT_W)) u_timer_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .tick_in(1'b1),
      .gate(peripheral_clock_ctrl_reg[CCG_TMR_BIT]),
      .div_sel(peripheral_clock_ctrl_reg[CCG_TDIV_LSB +: DIV_SEL_W]),
      .tick_out(timer_clk_tick),
      .active_sel()
   );

   // ****************************************
   // Gates and trims
   // ****************************************
   assign otp_clk_gate = bus_clock_divider_ctrl_reg[CCG_OTP_BIT];
   assign quad_clk_gate = peripheral_clock_ctrl_reg[CCG_QUAD_BIT];
   assign first_uart_clock_gate = peripheral_clock_ctrl_reg[CCG_UART1_BIT];
   assign second_uart_clock_gate = peripheral_clock_ctrl_reg[CCG_UART2_BIT];
   assign i2c_clk_gate = peripheral_clock_ctrl_reg[CCG_I2C_BIT];
   assign wakeup_capture_timer_clock_gate = peripheral_clock_ctrl_reg[CCG_WKUP_BIT];
   assign general_timer_clock_gate = peripheral_clock_ctrl_reg[CCG_TMR_BIT];
   assign xtal_coarse_trim = crystal_trim_ctrl_reg[CCG_COARSE_LSB +: 3];
   assign xtal_fine_trim = crystal_trim_ctrl_reg[CCG_FINE_LSB +: 8];

   // ****************************************
   // Assertions
   // ****************************************
   logic [3:0] hclk_gap_reg;
   logic hclk_seen_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hclk_gap_reg <= 4'h0;
         hclk_seen_reg <= 1'b0;
      end else if (ce) begin
         hclk_gap_reg <= hclk_tick ? 4'h1 : ((hclk_gap_reg == 4'hF) ? 4'hF : hclk_gap_reg + 4'h1);
         hclk_seen_reg <= hclk_seen_reg || hclk_tick;
      end
   end

   property p_hclk_period;
      @(posedge mclk) disable iff (!rst_n)
      (ce && $past(ce) && hclk_tick && hclk_seen_reg)
         |-> (hclk_gap_reg == (4'h1 << $past(hclk_active)));
   endproperty
   a_hclk_period: assert property (p_hclk_period) else $error("AHB tick period wrong");

   property p_pclk_after_hclk;
      @(posedge mclk) disable iff (!rst_n)
      (ce && $past(ce) && pclk_tick) |-> $past(hclk_tick);
   endproperty
   a_pclk_after_hclk: assert property (p_pclk_after_hclk) else $error("APB tick not on AHB tick");

   property p_otp_write;
      @(posedge mclk) disable iff (!rst_n)
      (ce && wr_bus && wstrb_reg[0]) |=> (otp_clk_gate == $past(wdata_reg[CCG_OTP_BIT]));
   endproperty
   a_otp_write: assert property (p_otp_write) else $error("OTP gate did not follow write");

   property p_coarse_write;
      @(posedge mclk) disable iff (!rst_n)
      (ce && wr_trim && wstrb_reg[1]) |=> (xtal_coarse_trim == $past(wdata_reg[10:8]));
   endproperty
   a_coarse_write: assert property (p_coarse_write) else $error("Coarse trim not stored");

   property p_fine_hold;
      @(posedge mclk) disable iff (!rst_n)
      (!wr_trim) |=> $stable(xtal_fine_trim);
   endproperty
   a_fine_hold: assert property (p_fine_hold) else $error("Fine trim changed without write");

   property p_quad_write;
      @(posedge mclk) disable iff (!rst_n)
      (ce && wr_per && wstrb_reg[1]) |=> (quad_clk_gate == $past(wdata_reg[CCG_QUAD_BIT]));
   endproperty
   a_quad_write: assert property (p_quad_write) else $error("Quadrature gate did not follow");

   property p_spi_gated;
      @(posedge mclk) disable iff (!rst_n)
      (!peripheral_clock_ctrl_reg[CCG_SPI_BIT]) [*2] |-> !spi_clk_tick;
   endproperty
   a_spi_gated: assert property (p_spi_gated) else $error("SPI tick while gated");

   property p_uart_write;
      @(posedge mclk) disable iff (!rst_n)
      (ce && wr_per && wstrb_reg[0]) |=> (first_uart_clock_gate == $past(wdata_reg[7])
         && second_uart_clock_gate == $past(wdata_reg[6]) && i2c_clk_gate == $past(wdata_reg[5]));
   endproperty
   a_uart_write: assert property (p_uart_write) else $error("Peripheral gates did not follow");

   property p_wakeup_write;
      @(posedge mclk) disable iff (!rst_n)
      (ce && wr_per && wstrb_reg[0])
         |=> (wakeup_capture_timer_clock_gate == $past(wdata_reg[CCG_WKUP_BIT]));
   endproperty
   a_wakeup_write: assert property (p_wakeup_write) else $error("Wakeup gate did not follow");

   property p_timer_gated;
      @(posedge mclk) disable iff (!rst_n)
      (!general_timer_clock_gate) [*2] |-> !timer_clk_tick;
   endproperty
   a_timer_gated: assert property (p_timer_gated) else $error("Timer tick while gated");

   property p_reserved_zero;
      @(posedge mclk) disable iff (!rst_n)
      rvalid_reg |-> (rdata_reg[31:16] == 16'h0000)
         && ((bus_clock_divider_ctrl_reg & ~CCG_BUS_MASK) == 16'h0000)
         && ((peripheral_clock_ctrl_reg & ~CCG_PER_MASK) == 16'h0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero");

   c_write_done: cover property (@(posedge mclk) disable iff (!rst_n) b_done && bresp_reg == 2'h0);
   c_read_done: cover property (@(posedge mclk) disable iff (!rst_n) r_done && rresp_reg == 2'h0);
   c_spi_tick: cover property (@(posedge mclk) disable iff (!rst_n) spi_clk_tick);
   c_hclk_change: cover property (@(posedge mclk) disable iff (!rst_n) hclk_tick && hclk_active == 2'h0);
endmodule : ccg_clock_ctrl
`default_nettype wire

// ===== verilog/ccg_div_tick.sv
// Power-of-two tick divider with glitch-free setting change and gate
`timescale 1ns/1ps
`default_nettype none
module ccg_div_tick #(
   parameter int SEL_W = 2,
   parameter int CNT_W = 3
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tick_in,
   input wire logic gate,
   input wire logic [SEL_W-1:0] div_sel,
   output logic tick_out,
   output logic [SEL_W-1:0] active_sel
);
   logic [CNT_W-1:0] cnt_reg;
   logic [SEL_W-1:0] sel_reg;
   logic tick_reg;
   wire logic [CNT_W-1:0] last_cnt = CNT_W'((1 << sel_reg) - 1);
   wire logic terminal = tick_in && (cnt_reg >= last_cnt);

   // New setting taken only at a period boundary
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         sel_reg <= '0;
         tick_reg <= 1'b0;
      end else if (ce) begin
         if (terminal) begin
            cnt_reg <= '0;
            sel_reg <= div_sel;
         end else if (tick_in) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
         end
         tick_reg <= terminal && gate;
      end
   end

   assign tick_out = tick_reg;
   assign active_sel = sel_reg;
endmodule : ccg_div_tick
`default_nettype wire

// ===== verilog/ccg_pkg.sv
// Constants, register layout and bus carriers of the clock control block
package ccg_pkg;

   // ****************************************
   // Register map
   // ****************************************
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [31:0] CCG_IDX_BASE = 32'h5000_0000;
   localparam logic [31:0] CCG_IDX_BUS = 32'h5000_0000;
   localparam logic [31:0] CCG_IDX_TRIM = 32'h5000_0002;
   localparam logic [31:0] CCG_IDX_PER = 32'h5000_0004;
   localparam int CCG_ADDR_W = 8;
   localparam logic [CCG_ADDR_W-1:0] CCG_ADDR_BUS = CCG_ADDR_W'((CCG_IDX_BUS - CCG_IDX_BASE) * 4);
   localparam logic [CCG_ADDR_W-1:0] CCG_ADDR_TRIM = CCG_ADDR_W'((CCG_IDX_TRIM - CCG_IDX_BASE) * 4);
   localparam logic [CCG_ADDR_W-1:0] CCG_ADDR_PER = CCG_ADDR_W'((CCG_IDX_PER - CCG_IDX_BASE) * 4);

   // ****************************************
   // Reset values and writable masks
   // ****************************************
   localparam logic [15:0] CCG_BUS_RST = 16'h0022;
   localparam logic [15:0] CCG_TRIM_RST = 16'h0000;
   localparam logic [15:0] CCG_PER_RST = 16'h0000;
   localparam logic [15:0] CCG_BUS_MASK = 16'h00B3;
   localparam logic [15:0] CCG_TRIM_MASK = 16'h07FF;
   localparam logic [15:0] CCG_PER_MASK = 16'h8BFB;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CCG_HDIV_LSB = 0;
   localparam int CCG_PDIV_LSB = 4;
   localparam int CCG_OTP_BIT = 7;
   localparam int CCG_FINE_LSB = 0;
   localparam int CCG_COARSE_LSB = 8;
   localparam int CCG_TDIV_LSB = 0;
   localparam int CCG_TMR_BIT = 3;
   localparam int CCG_WKUP_BIT = 4;
   localparam int CCG_I2C_BIT = 5;
   localparam int CCG_UART2_BIT = 6;
   localparam int CCG_UART1_BIT = 7;
   localparam int CCG_SDIV_LSB = 8;
   localparam int CCG_SPI_BIT = 11;
   localparam int CCG_QUAD_BIT = 15;

   // ****************************************
   // Divider and bus codes
   // ****************************************
   localparam int CCG_DIV_SEL_W = 2;
   localparam int CCG_DIV_CNT_W = 3;
   localparam logic [1:0] CCG_RESP_OKAY = 2'h0;
   localparam logic [1:0] CCG_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [CCG_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [CCG_ADDR_W-1:0] araddr;
      logic rready;
   } ccg_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ccg_axi_rsp_t;

endpackage : ccg_pkg
